/* File: rtl/aprr_pkg.sv */
// Package for the serial audio port test and reduced-rate block.
// Assumes one 20 MHz clock; all pin timing is sampled on that clock.
package aprr_pkg;

   // Frame geometry
   localparam int unsigned SLOT_W       = 32;
   localparam logic [4:0]  SLOT_LAST    = 5'h1f;

   // Sampled pin vector positions
   localparam int unsigned PIN_BCLK     = 0;
   localparam int unsigned PIN_FSYNC    = 1;
   localparam int unsigned PIN_IN0      = 2;
   localparam int unsigned PIN_IN1      = 3;
   localparam int unsigned PIN_GP7      = 4;
   localparam int unsigned PIN_NUM      = 5;

   // Test control register fields
   localparam int unsigned TST_PIN_LOOP = 4;
   localparam int unsigned TST_SEL_RX1  = 3;
   localparam int unsigned TST_CAPTURE  = 2;
   localparam int unsigned TST_BUF_TX   = 1;
   localparam int unsigned TST_PATTERN  = 0;
   localparam logic [7:0]  TST_MASK     = 8'h1f;

   // Reduced-rate configuration fields
   localparam int unsigned RRT_ENABLE   = 7;
   localparam int unsigned RRT_DIV_LSB  = 0;
   localparam int unsigned RRT_DIV_W    = 6;
   localparam logic [7:0]  RRT_MASK     = 8'hbf;

   // Reduced-rate control fields
   localparam int unsigned RRC_DIR      = 5;
   localparam int unsigned RRC_STROBE   = 4;
   localparam int unsigned RRC_XBIT     = 1;
   localparam int unsigned RRC_VLSB     = 0;
   localparam logic [7:0]  RRC_MASK     = 8'h33;

   // Sync offset field
   localparam int unsigned OFS_W        = 2;
   localparam logic [7:0]  OFS_MASK     = 8'h03;

   localparam logic [7:0]  REG_RESET    = 8'h00;

   typedef enum logic [1:0] {
      APRR_SEL_TEST  = 2'b00,
      APRR_SEL_RRATE = 2'b01,
      APRR_SEL_RRCTL = 2'b10,
      APRR_SEL_OFFS  = 2'b11
   } aprr_sel_type;

   typedef enum logic [2:0] {
      APRR_TX_NORMAL  = 3'b000,
      APRR_TX_PATTERN = 3'b001,
      APRR_TX_LIVE    = 3'b010,
      APRR_TX_REPEAT  = 3'b011,
      APRR_TX_DEFAULT = 3'b100
   } aprr_mode_type;

   typedef struct packed {
      logic         valid;
      aprr_sel_type sel;
      logic         from_bus;
      logic [7:0]   data;
   } aprr_wr_type;

   typedef struct packed {
      logic [7:0] test;
      logic [7:0] rrate;
      logic [7:0] rrctl;
      logic [7:0] offs;
   } aprr_regs_type;

   function automatic logic aprr_div_legal(input logic [5:0] d);
      case (d)
         6'h01, 6'h02, 6'h04, 6'h08, 6'h0c,
         6'h10, 6'h14, 6'h18, 6'h1c, 6'h20: aprr_div_legal = 1'b1;
         default:                           aprr_div_legal = 1'b0;
      endcase
   endfunction

endpackage

/* File: rtl/aprr_port.sv */
// Serial audio port test modes, loop buffer and reduced-rate framing.
// Assumes bit clock and frame sync arrive from a host far slower than clk.
// How it works
// - Pin loopback feeds outputs back into inputs.
// - Pin loopback overrides all other test controls.
// - Input select picks receiver for the buffer.
// - Capture stores selected input into frame buffer.
// - Buffer-to-transmit sends buffer on both outputs.
// - Buffer-to-transmit without capture sends default pattern until a frame is held.
// - Capture cleared: last captured frame repeats.
// - Pattern bit sends default pattern everywhere.
// - Pattern bit yields to buffer-to-transmit.
// - Master local rate write is broadcast.
// - Slave ignores local rate writes.
// - Reduced rate delivers data once per divider.
// - Divider accepts only the listed values.
// - Strobe direction; input strobe realigns frames.
// - Strobe enable with output direction drives pin 7 on data frames.
// - Extra bit after LSB marks new data.
// - Reduced-rate slave marks new samples in LSB.
// - Slave LSB plus master extra bit give pairs.
// - Shared slot marks first sample in extra bit.
// - Slave shifts data frame earlier by offset.
`timescale 1ns/1ps
`default_nettype none

module aprr_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } aprr_fifo_st_type;

   aprr_fifo_st_type st_r;
   aprr_fifo_st_type st_nxt;
   logic [AW:0]      fill;

   always_comb begin
      st_nxt    = st_r;
      fill      = st_r.wp - st_r.rp;
      in_ready  = (fill != (AW+1)'(DEPTH));
      out_valid = (st_r.wp != st_r.rp);
      out_data  = st_r.mem[st_r.rp[AW-1:0]];
      if (in_valid && in_ready) begin
         st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // aprr_fifo

module aprr_port
   import aprr_pkg::*;
#(
   parameter int unsigned CHANNELS  = 2,
   parameter int unsigned DATA_W    = 24,
   parameter int unsigned BUF_DEPTH = 32,
   parameter logic [31:0] PATTERN   = 32'h5a5a_a5a5
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // Node role and normal port settings
   input  wire logic                    is_master,
   input  wire logic                    shared_slot_setting,
   input  wire logic                    receiver_0_en,
   input  wire logic                    receiver_1_en,
   input  wire logic                    transmitter_0_en,
   input  wire logic                    transmitter_1_en,
   // Register access
   input  wire aprr_pkg::aprr_wr_type   reg_wr,
   output aprr_pkg::aprr_regs_type      regs,
   output aprr_pkg::aprr_wr_type        bcast_wr,
   output logic [5:0]                   frame_phase,
   // Serial pins
   input  wire logic                    bclk,
   input  wire logic                    frame_sync,
   input  wire logic                    serial_in_0,
   input  wire logic                    serial_in_1,
   output logic                         serial_out_0,
   output logic                         serial_out_1,
   input  wire logic                    general_pin_7_in,
   output logic                         general_pin_7_out,
   output logic                         general_pin_7_oe,
   // Audio words
   input  wire logic [SLOT_W-1:0]       tx_data_0,
   input  wire logic [SLOT_W-1:0]       tx_data_1,
   output logic                         tx_load,
   output logic [SLOT_W-1:0]            rx_data_0,
   output logic [SLOT_W-1:0]            rx_data_1,
   output logic                         rx_valid,
   output logic                         loop_buf_ready
);
   import aprr_pkg::*;

   localparam int unsigned CW      = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
   localparam int unsigned LSB_POS = SLOT_W - DATA_W;
   localparam int unsigned XB_POS  = LSB_POS - 1;

   typedef struct packed {
      logic [PIN_NUM-1:0]               s1;
      logic [PIN_NUM-1:0]               s2;
      logic [PIN_NUM-1:0]               s3;
      logic [PIN_NUM-1:0]               f;
      aprr_regs_type                    regs;
      logic [4:0]                       bit_cnt;
      logic [CW-1:0]                    ch;
      logic [SLOT_W-1:0]                rsh0;
      logic [SLOT_W-1:0]                rsh1;
      logic [SLOT_W-1:0]                txw0;
      logic [SLOT_W-1:0]                txw1;
      aprr_mode_type                    src;
      logic                             out0;
      logic                             out1;
      logic [5:0]                       rr_cnt;
      logic                             new_frame;
      logic                             have_frame;
      logic [CHANNELS-1:0][SLOT_W-1:0]  last;
      logic [SLOT_W-1:0]                rx0;
      logic [SLOT_W-1:0]                rx1;
      logic                             rx_valid;
      logic                             tx_load;
      aprr_wr_type                      bcast;
   } aprr_st_type;

   aprr_st_type        st_r;
   aprr_st_type        st_nxt;
   logic [PIN_NUM-1:0] agree;
   logic [PIN_NUM-1:0] rise;
   logic [PIN_NUM-1:0] fall;
   logic               pl;
   logic               cap;
   logic               b2t;
   logic               pat;
   logic               slow;
   logic               lsb_on;
   logic               xb_on;
   logic               word_done;
   logic               do_load;
   logic [CW-1:0]      load_ch;
   logic [SLOT_W-1:0]  w0;
   logic [SLOT_W-1:0]  w1;
   logic [SLOT_W-1:0]  lw;
   logic [5:0]         div_eff;
   logic [5:0]         cnt_n;
   logic [5:0]         target;
   logic               rxb0;
   logic               rxb1;
   aprr_mode_type      mode_c;
   logic               fifo_in_valid;
   logic [SLOT_W-1:0]  fifo_in_data;
   logic               fifo_out_valid;
   logic [SLOT_W-1:0]  fifo_out_data;
   logic               fifo_out_ready;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.rx_valid = 1'b0;
      st_nxt.tx_load  = 1'b0;
      st_nxt.bcast    = '0;
      fifo_out_ready  = 1'b0;
      lw              = '0;
      // Pin filter: a level counts once the second and third stage agree
      st_nxt.s1 = {general_pin_7_in, serial_in_1, serial_in_0,
                   frame_sync, bclk};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      agree     = ~(st_r.s2 ^ st_r.s3);
      st_nxt.f  = (st_r.s2 & agree) | (st_r.f & ~agree);
      rise      = st_nxt.f & ~st_r.f;
      fall      = ~st_nxt.f & st_r.f;

      // Register writes
      if (reg_wr.valid) begin
         unique case (reg_wr.sel)
            APRR_SEL_TEST:  st_nxt.regs.test = reg_wr.data & TST_MASK;
            APRR_SEL_RRATE: begin
               // Illegal dividers drop the whole write
               if ((is_master || reg_wr.from_bus) &&
                   aprr_div_legal(reg_wr.data[5:0])) begin
                  st_nxt.regs.rrate = reg_wr.data & RRT_MASK;
                  if (is_master && !reg_wr.from_bus) begin
                     st_nxt.bcast = reg_wr;
                  end
               end
            end
            APRR_SEL_RRCTL: st_nxt.regs.rrctl = reg_wr.data & RRC_MASK;
            APRR_SEL_OFFS:  st_nxt.regs.offs  = reg_wr.data & OFS_MASK;
         endcase
      end

      // Test controls; pin loopback masks the rest
      pl  = st_r.regs.test[TST_PIN_LOOP];
      cap = !pl && st_r.regs.test[TST_CAPTURE];
      b2t = !pl && st_r.regs.test[TST_BUF_TX];
      pat = !pl && !b2t && st_r.regs.test[TST_PATTERN];
      if (b2t) begin
         mode_c = cap ? APRR_TX_LIVE :
                  (st_r.have_frame ? APRR_TX_REPEAT : APRR_TX_DEFAULT);
      end else if (pat) begin
         mode_c = APRR_TX_PATTERN;
      end else begin
         mode_c = APRR_TX_NORMAL;
      end
      if (!b2t) begin
         st_nxt.have_frame = 1'b0;
      end

      // Reduced-rate valid marking: LSB for a slave node, extra bit for a master or a shared slot
      slow   = st_r.regs.rrate[RRT_ENABLE];
      lsb_on = st_r.regs.rrctl[RRC_VLSB] && slow && !is_master;
      xb_on  = (st_r.regs.rrctl[RRC_XBIT] && !(slow && !is_master)) ||
               (shared_slot_setting && slow && !is_master);

      // Loopback swaps the pins for the driven bits
      rxb0 = pl ? st_r.out0 : st_r.f[PIN_IN0];
      rxb1 = pl ? st_r.out1 : st_r.f[PIN_IN1];
      w0   = {st_r.rsh0[SLOT_W-2:0], rxb0};
      w1   = {st_r.rsh1[SLOT_W-2:0], rxb1};
      word_done     = rise[PIN_BCLK] && !rise[PIN_FSYNC] &&
                      (st_r.bit_cnt == SLOT_LAST);
      fifo_in_valid = cap && word_done;
      fifo_in_data  = st_r.regs.test[TST_SEL_RX1] ? w1 : w0;

      // Frame counting at each frame sync
      div_eff = (st_r.regs.rrate[5:0] == 6'h00) ? 6'h01 :
                st_r.regs.rrate[5:0];
      if (!slow) begin
         cnt_n = 6'h00;
      end else if (st_r.regs.rrctl[RRC_STROBE] &&
                   !st_r.regs.rrctl[RRC_DIR] && st_nxt.f[PIN_GP7]) begin
         cnt_n = 6'h00;
      end else if (st_r.rr_cnt + 6'h01 >= div_eff) begin
         cnt_n = 6'h00;
      end else begin
         cnt_n = st_r.rr_cnt + 6'h01;
      end
      if (is_master || st_r.regs.offs[OFS_W-1:0] == 2'h0 ||
          {4'h0, st_r.regs.offs[OFS_W-1:0]} >= div_eff) begin
         target = 6'h00;
      end else begin
         target = div_eff - {4'h0, st_r.regs.offs[OFS_W-1:0]};
      end

      do_load = 1'b0;
      load_ch = st_r.ch;
      if (rise[PIN_FSYNC]) begin
         st_nxt.bit_cnt   = 5'h00;
         st_nxt.rr_cnt    = cnt_n;
         st_nxt.new_frame = !slow || (cnt_n == target);
         do_load          = 1'b1;
         load_ch          = '0;
      end else if (rise[PIN_BCLK]) begin
         st_nxt.rsh0    = w0;
         st_nxt.rsh1    = w1;
         st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
         if (word_done) begin
            // After the last slot, slot 0 waits for the next sync so a
            // frame never pops the loop buffer twice for one slot
            load_ch = st_r.ch + 1'b1;
            do_load = (st_r.ch != CW'(CHANNELS - 1));
            // Only frames carrying new data reach the user side
            if (!cap && (!slow || st_r.new_frame)) begin
               st_nxt.rx_valid = 1'b1;
               st_nxt.rx0 = receiver_0_en ? w0 : '0;
               st_nxt.rx1 = receiver_1_en ? w1 : '0;
            end
         end
      end else if (fall[PIN_BCLK]) begin
         st_nxt.out0 = st_r.txw0[SLOT_LAST - st_r.bit_cnt];
         st_nxt.out1 = st_r.txw1[SLOT_LAST - st_r.bit_cnt];
      end

      if (do_load) begin
         st_nxt.ch  = load_ch;
         st_nxt.src = mode_c;
         unique case (mode_c)
            APRR_TX_NORMAL: begin
               st_nxt.tx_load = 1'b1;
               st_nxt.txw0 = transmitter_0_en ? tx_data_0 : '0;
               st_nxt.txw1 = transmitter_1_en ? tx_data_1 : '0;
               if (lsb_on) begin
                  // At sync this frame's flag exists only in st_nxt
                  st_nxt.txw0[LSB_POS] = st_nxt.new_frame;
                  st_nxt.txw1[LSB_POS] = st_nxt.new_frame;
               end
               if (xb_on) begin
                  st_nxt.txw0[XB_POS] = st_nxt.new_frame;
                  st_nxt.txw1[XB_POS] = st_nxt.new_frame;
               end
            end
            APRR_TX_PATTERN, APRR_TX_DEFAULT: begin
               st_nxt.txw0 = PATTERN;
               st_nxt.txw1 = PATTERN;
            end
            APRR_TX_LIVE: begin
               // An empty buffer resends the word from the previous frame
               fifo_out_ready = 1'b1;
               lw = fifo_out_valid ? fifo_out_data : st_r.last[load_ch];
               st_nxt.last[load_ch] = lw;
               st_nxt.have_frame    = 1'b1;
               st_nxt.txw0 = lw;
               st_nxt.txw1 = lw;
            end
            APRR_TX_REPEAT: begin
               st_nxt.txw0 = st_r.last[load_ch];
               st_nxt.txw1 = st_r.last[load_ch];
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Source cannot stall the pins, so a full buffer drops captured words
   aprr_fifo #(
      .WIDTH (SLOT_W),
      .DEPTH (BUF_DEPTH)
   ) u_loop_buf (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_in_valid),
      .in_data   (fifo_in_data),
      .in_ready  (loop_buf_ready),
      .out_valid (fifo_out_valid),
      .out_data  (fifo_out_data),
      .out_ready (fifo_out_ready)
   );

   assign regs              = st_r.regs;
   assign bcast_wr          = st_r.bcast;
   assign frame_phase       = st_r.rr_cnt;
   assign serial_out_0      = st_r.out0;
   assign serial_out_1      = st_r.out1;
   assign general_pin_7_oe  = st_r.regs.rrctl[RRC_STROBE] &&
                              st_r.regs.rrctl[RRC_DIR];
   assign general_pin_7_out = general_pin_7_oe && st_r.new_frame;
   assign tx_load           = st_r.tx_load;
   assign rx_data_0         = st_r.rx0;
   assign rx_data_1         = st_r.rx1;
   assign rx_valid          = st_r.rx_valid;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_local_rate_wr;
      reg_wr.valid && reg_wr.sel == APRR_SEL_RRATE && !reg_wr.from_bus &&
      aprr_div_legal(reg_wr.data[5:0]);
   endsequence

   chk_pin_loop_route: assert property (
      (pl && rise[PIN_BCLK] && !rise[PIN_FSYNC])
      |=> st_r.rsh0[0] == $past(st_r.out0) && st_r.rsh1[0] == $past(st_r.out1))
      else $error("pin loopback did not return driven bits");
   chk_loop_masks_test: assert property (
      pl |-> mode_c == APRR_TX_NORMAL && !fifo_in_valid)
      else $error("test controls active during pin loopback");
   chk_sel_rx_feed: assert property (
      fifo_in_valid |-> fifo_in_data == (st_r.regs.test[TST_SEL_RX1] ? w1 : w0))
      else $error("wrong receiver feeds loop buffer");
   chk_capture_push: assert property (
      (cap && word_done) |-> fifo_in_valid)
      else $error("captured word not offered to buffer");
   chk_dup_outputs: assert property (
      st_r.src != APRR_TX_NORMAL |-> st_r.txw0 == st_r.txw1)
      else $error("test source differs between outputs");
   chk_default_word: assert property (
      st_r.src inside {APRR_TX_PATTERN, APRR_TX_DEFAULT} |-> st_r.txw0 == PATTERN)
      else $error("default pattern not loaded");
   chk_repeat_frame: assert property (
      st_r.src == APRR_TX_REPEAT |-> st_r.txw1 == st_r.last[st_r.ch])
      else $error("repeat mode lost the held frame");
   chk_pattern_yield: assert property (
      b2t |-> mode_c != APRR_TX_PATTERN)
      else $error("pattern overrides buffer transmit");
   chk_bcast_write: assert property (
      (s_local_rate_wr and is_master) |=> bcast_wr.valid &&
      bcast_wr.data == $past(reg_wr.data) ##1 !bcast_wr.valid)
      else $error("master rate write not broadcast once");
   chk_slave_ignore: assert property (
      (s_local_rate_wr and !is_master) |=> $stable(regs.rrate) && !bcast_wr.valid)
      else $error("slave took a local rate write");
   chk_rx_gating: assert property (
      (rx_valid && $past(slow)) |-> $past(st_r.new_frame))
      else $error("data delivered in a repeat frame");
   chk_div_legal: assert property (
      regs.rrate[5:0] == 6'h00 || aprr_div_legal(regs.rrate[5:0]))
      else $error("illegal divider stored");
   chk_strobe_realign: assert property (
      (rise[PIN_FSYNC] && cnt_n == 6'h00 && slow && st_nxt.f[PIN_GP7] &&
       st_r.regs.rrctl[RRC_STROBE] && !st_r.regs.rrctl[RRC_DIR])
      |=> frame_phase == 6'h00 && st_r.new_frame == (target == 6'h00))
      else $error("input strobe did not realign frames");
   chk_reset_clear: assert property (
      $past(sys_rst) |-> regs == '0 && !general_pin_7_oe)
      else $error("controls not cleared by reset");
endmodule // aprr_port

`default_nettype wire

/* File: dv/aprr_host.sv */
// Host model: bit clock, frame sync and the two data input pins.
// Assumes clk at 20 MHz; bit clock is 8 clk and stops between frames.
`timescale 1ns/1ps
`default_nettype none
module aprr_host (
   // Clock
   input  wire logic clk,
   // Host pins
   output var logic  bclk,
   output var logic  frame_sync,
   output var logic  din_0,
   output var logic  din_1,
   // Device pins
   input  wire logic dout_0,
   input  wire logic dout_1
);
   initial begin
      bclk = 1'b0;
      frame_sync = 1'b0;
      din_0 = 1'b0;
      din_1 = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   // Two 32-bit slots, MSB first; sync rises with a bit clock rise
   task automatic frame(input logic [63:0] i0, input logic [63:0] i1,
                        output logic [63:0] o0, output logic [63:0] o1);
      half();
      bclk <= 1'b1;
      frame_sync <= 1'b1;
      half();
      for (int n = 0; n <= 64; n++) begin
         bclk <= 1'b0;
         frame_sync <= 1'b0;
         if (n > 0) begin
            o0[64-n] = dout_0;
            o1[64-n] = dout_1;
         end
         if (n < 64) begin
            din_0 <= i0[63-n];
            din_1 <= i1[63-n];
            half();
            bclk <= 1'b1;
            half();
         end
      end
      // Released lines must not keep the last bit
      din_0 <= ~din_0;
      din_1 <= ~din_1;
      half();
   endtask
endmodule // aprr_host
`default_nettype wire

/* File: dv/testbench.sv */
// Bench for the serial port test modes and reduced-rate framing.
// Assumes the host model drives the pins; registers via reg_wr.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import aprr_pkg::*;
   localparam logic [31:0] PAT = 32'hc3a5_0f96;
   localparam logic [31:0] TX0 = 32'h1234_5600;
   localparam logic [31:0] TX1 = 32'hfedc_ba00;
   localparam logic [63:0] A   = 64'ha1b2_c3d4_0f1e_2d3c;
   localparam logic [63:0] B   = 64'h9669_5aa5_3cc3_f00f;
   localparam logic [7:0]  DIVS [10] = '{8'h01, 8'h02, 8'h04, 8'h08,
      8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
   logic          clk = 1'b0, sys_rst = 1'b1, mst = 1'b1, shr = 1'b0;
   logic          gp7_in = 1'b0, bclk, fs, si0, si1, so0, so1;
   logic          gp7_out, gp7_oe, rxv, tld, lbr;
   logic [3:0]    en = 4'h5;
   aprr_wr_type   reg_wr = '0;
   aprr_wr_type   bcast_wr;
   aprr_regs_type regs;
   logic [5:0]    frame_phase;
   logic [31:0]   rx0, rx1;
   logic [63:0]   o0, o1, rxq;
   logic [7:0]    bcd;
   int            errors = 0, checks = 0, cyc = 0, rxn = 0, bcn = 0;
   int            tln = 0;
   aprr_port #(.PATTERN(PAT)) DUT (.clk(clk), .sys_rst(sys_rst),
      .is_master(mst), .shared_slot_setting(shr), .receiver_0_en(en[0]),
      .receiver_1_en(en[1]), .transmitter_0_en(en[2]),
      .transmitter_1_en(en[3]), .reg_wr(reg_wr), .regs(regs),
      .bcast_wr(bcast_wr), .frame_phase(frame_phase), .bclk(bclk),
      .frame_sync(fs), .serial_in_0(si0), .serial_in_1(si1),
      .serial_out_0(so0), .serial_out_1(so1), .general_pin_7_in(gp7_in),
      .general_pin_7_out(gp7_out), .general_pin_7_oe(gp7_oe),
      .tx_data_0(TX0), .tx_data_1(TX1), .tx_load(tld), .rx_data_0(rx0),
      .rx_data_1(rx1), .rx_valid(rxv), .loop_buf_ready(lbr));
   aprr_host host (.clk(clk), .bclk(bclk), .frame_sync(fs), .din_0(si0),
      .din_1(si1), .dout_0(so0), .dout_1(so1));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rxv === 1'b1) begin
         rxn <= rxn + 1;
         rxq <= {rx0, rx1};
      end
      if (tld === 1'b1) begin
         tln <= tln + 1;
      end
      if (bcast_wr.valid === 1'b1) begin
         bcn <= bcn + 1;
         bcd <= bcast_wr.data;
      end
      // Over twice the expected run
      if (cyc == 30000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cmp(input string n, input logic [63:0] e,
                      input logic [63:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp_out(input string n, input logic [63:0] e);
      cmp({n, "0"}, e, o0);
      cmp({n, "1"}, e, o1);
   endtask
   task automatic wr(input aprr_sel_type s, input logic [7:0] d,
                     input logic b);
      reg_wr <= '{valid: 1'b1, sel: s, from_bus: b, data: d};
      @(posedge clk);
      reg_wr <= '0;
      repeat (2) @(posedge clk);
   endtask
   task automatic do_reset();
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fr(input logic [63:0] i0, input logic [63:0] i1);
      host.frame(i0, i1, o0, o1);
   endtask
   // Four frames: strobe highs, last high frame, extra and LSB marks
   task automatic run4(output int hi, output int idx, output int m7,
                       output int m8);
      hi = 0;
      idx = 0;
      m7 = 0;
      m8 = 0;
      for (int f = 0; f < 4; f++) begin
         fr(A, B);
         if (gp7_out === 1'b1) begin
            hi++;
            idx = f;
         end
         m7 += o0[39] + o0[7];
         m8 += o0[40] + o0[8];
      end
   endtask
   initial begin
      int hi, idx, i0, m7, m8, n;
      do_reset();
      cmp("regs", 64'h0, regs);
      foreach (DIVS[k]) begin
         n = bcn;
         wr(APRR_SEL_RRATE, DIVS[k], 1'b0);
         cmp("rrate", DIVS[k], regs.rrate);
         cmp("bcast", {bcn - n, bcd}, {32'd1, DIVS[k]});
      end
      wr(APRR_SEL_RRATE, 8'ha1, 1'b0);
      cmp("bad div", 8'h20, regs.rrate);
      wr(APRR_SEL_RRATE, 8'h01, 1'b0);
      n = tln;
      fr(A, B);
      cmp("tx_load", 64'd2, tln - n);
      cmp("out0", {TX0, TX0}, o0);
      cmp("out1", 64'h0, o1);
      cmp("rx", {A[31:0], 32'h0}, rxq);
      en <= 4'hf;
      wr(APRR_SEL_TEST, 8'h01, 1'b0);
      n = tln;
      fr(A, B);
      cmp("pattern load", 64'd0, tln - n);
      cmp_out("pattern", {PAT, PAT});
      wr(APRR_SEL_TEST, 8'h02, 1'b0);
      fr(A, B);
      cmp_out("default", {PAT, PAT});
      wr(APRR_SEL_TEST, 8'h07, 1'b0);
      fr(A, B);
      fr(B, A);
      cmp_out("capture", A);
      cmp("buf ready", 64'h1, lbr);
      wr(APRR_SEL_TEST, 8'h0e, 1'b0);
      fr(A, B);
      fr(A, B);
      cmp_out("select", B);
      wr(APRR_SEL_TEST, 8'h0a, 1'b0);
      fr(B, A);
      fr(B, A);
      cmp_out("repeat", B);
      wr(APRR_SEL_TEST, 8'h1e, 1'b0);
      fr(A, B);
      cmp("loop out0", {TX0, TX0}, o0);
      cmp("loop out1", {TX1, TX1}, o1);
      cmp("loop rx", {TX0, TX1}, rxq);
      wr(APRR_SEL_TEST, 8'h00, 1'b0);
      wr(APRR_SEL_RRATE, 8'h82, 1'b0);
      wr(APRR_SEL_RRCTL, 8'h32, 1'b0);
      cmp("oe out", 64'h1, gp7_oe);
      n = rxn;
      run4(hi, idx, m7, m8);
      cmp("master", {16'(hi), 16'(m7), 16'(m8), 16'(rxn - n)},
          {16'd2, 16'd4, 16'd0, 16'd4});
      mst <= 1'b0;
      do_reset();
      shr <= 1'b1;
      wr(APRR_SEL_RRATE, 8'h84, 1'b0);
      cmp("local", 64'h0, regs.rrate);
      wr(APRR_SEL_RRATE, 8'h84, 1'b1);
      wr(APRR_SEL_RRCTL, 8'h31, 1'b0);
      cmp("bus", 8'h84, regs.rrate);
      n = rxn;
      run4(hi, i0, m7, m8);
      cmp("slave", {16'(hi), 16'(m7), 16'(m8), 16'(rxn - n)},
          {16'd1, 16'd2, 16'd2, 16'd2});
      wr(APRR_SEL_OFFS, 8'h01, 1'b0);
      run4(hi, idx, m7, m8);
      cmp("offset", (i0 + 3) % 4, idx);
      wr(APRR_SEL_RRCTL, 8'h10, 1'b0);
      cmp("oe in", 64'h0, gp7_oe);
      gp7_in <= 1'b1;
      fr(A, B);
      gp7_in <= 1'b0;
      cmp("phase", 64'h0, frame_phase);
      fr(A, B);
      cmp("phase", 64'h1, frame_phase);
      stop_test();
   end
endmodule // testbench
`default_nettype wire
